// file: verilog/flash_read_pkg.sv
// Shared constants and types of the serial flash read engine
package flash_read_pkg;

  // Read instruction codes
  localparam logic [7:0] OP_READ           = 8'h03;  // Plain single-line read
  localparam logic [7:0] OP_FAST_READ      = 8'h0b;  // Single-line fast read
  localparam logic [7:0] OP_DUAL_OUT_READ  = 8'h3b;  // dual_output_read
  localparam logic [7:0] OP_DUAL_IO_READ   = 8'hbb;  // dual_io_read
  localparam logic [7:0] OP_QUAD_OUT_READ  = 8'h6b;  // quad_output_read
  localparam logic [7:0] OP_QUAD_IO_READ   = 8'heb;  // quad_io_read
  localparam logic [7:0] OP_QUAD_DTR_READ  = 8'hed;  // quad_io_double_rate_read

  // Widths and depths
  localparam int ADDR_W     = 24;  // Byte address width
  localparam int DATA_W     = 8;   // One flash byte
  localparam int FIFO_DEPTH = 8;   // Prefetch buffer depth

  // Lane counts
  localparam logic [2:0] LANES_1 = 3'h1;
  localparam logic [2:0] LANES_2 = 3'h2;
  localparam logic [2:0] LANES_4 = 3'h4;

  // Dummy clock counts
  localparam logic [3:0] DUMMY_NONE  = 4'h0;  // Plain read
  localparam logic [3:0] DUMMY_SDR   = 4'h8;  // Fast, dual-output, quad-output
  localparam logic [3:0] DUMMY_DIO_0 = 4'h4;  // Dual-I/O, selector low bit 0
  localparam logic [3:0] DUMMY_DIO_1 = 4'h8;  // Dual-I/O, selector low bit 1
  localparam logic [3:0] DUMMY_QIO_0 = 4'h6;  // Quad-I/O, selector 00
  localparam logic [3:0] DUMMY_QIO_1 = 4'h4;  // Quad-I/O, selector 01
  localparam logic [3:0] DUMMY_QIO_2 = 4'h8;  // Quad-I/O, selector 10
  localparam logic [3:0] DUMMY_QIO_3 = 4'ha;  // Quad-I/O, selector 11
  localparam logic [3:0] DUMMY_DTR_0 = 4'h6;  // Quad DTR, selectors 00 and 01
  localparam logic [3:0] DUMMY_DTR_2 = 4'h8;  // Quad DTR, selector 10
  localparam logic [3:0] DUMMY_DTR_3 = 4'ha;  // Quad DTR, selector 11

  // Register byte offsets
  localparam logic [3:0] REG_CTRL   = 4'h0;
  localparam logic [3:0] REG_CONFIG = 4'h4;
  localparam logic [3:0] REG_STATUS = 4'h8;
  localparam logic [3:0] REG_ADDR   = 4'hc;

  // Field positions
  localparam int CTRL_QUAD_ENABLE = 0;  // quad_enable_bit
  localparam int CTRL_FOUR_WIRE   = 1;  // four_wire_command_mode
  localparam int CTRL_BUSY        = 2;  // Internal write cycle running
  localparam int CFG_DC_LO        = 6;  // dummy_count_sel_lo
  localparam int CFG_DC_HI        = 7;  // dummy_count_sel_hi
  localparam int STAT_ENHANCE     = 0;  // Enhance mode active
  localparam int STAT_UNDERRUN    = 1;  // Sticky, write one to clear
  localparam int STAT_PENDING     = 2;  // Memory fetch outstanding
  localparam int STAT_PHASE_LSB   = 4;  // Three-bit phase code

  // Reset values
  localparam logic [2:0] CTRL_RESET   = 3'h0;
  localparam logic [7:0] CONFIG_RESET = 8'h00;

  // Fill byte when the prefetch buffer runs dry
  localparam logic [7:0] UNDERRUN_BYTE = 8'hff;

  // Frame phase
  typedef enum logic [2:0] {
    PH_CMD    = 3'h0,
    PH_ADDR   = 3'h1,
    PH_DUMMY  = 3'h2,
    PH_DATA   = 3'h3,
    PH_IGNORE = 3'h4
  } phase_t;

  // Decoded read variant
  typedef struct packed {
    logic       valid;       // Accepted instruction
    logic [2:0] addr_lanes;  // Lines per address edge
    logic [2:0] data_lanes;  // Lines per data edge
    logic       dtr;         // Both-edge transfer
    logic       mode_bits;   // Enhance indicator present
    logic [3:0] dummy;       // Dummy clocks, indicator included
  } read_mode_t;

  // Pin sample group
  typedef struct packed {
    logic       cs_n;
    logic       sclk;
    logic [3:0] sio;
  } pins_t;

  localparam pins_t PINS_IDLE = '{cs_n: 1'b1, sclk: 1'b0, sio: 4'h0};

endpackage : flash_read_pkg

// file: verilog/byte_fifo.sv
// Parameterised valid/ready FIFO with flush
`timescale 1ns/10ps
`default_nettype none
module byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input  wire logic             clock,
  input  wire logic             rst_n,
  input  wire logic             flush,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int IW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];  // Storage
  logic [IW-1:0]    wr_ptr;       // Write index
  logic [IW-1:0]    rd_ptr;       // Read index
  logic [IW:0]      count;        // Words held
  logic             push;
  logic             pop;

  // Wrap an index at the depth
  function automatic logic [IW-1:0] bump(input logic [IW-1:0] p);
    bump = (p == IW'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction : bump

  assign in_ready  = (count != (IW + 1)'(DEPTH));
  assign out_valid = (count != '0);
  assign out_data  = mem[rd_ptr];
  assign push      = in_valid && in_ready && !flush;
  assign pop       = out_valid && out_ready && !flush;

  // Storage write
  always_ff @(posedge clock)
  begin
    if (push)
    begin
      mem[wr_ptr] <= in_data;
    end
  end

  // Pointers and fill count
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end
    else if (flush)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end
    else
    begin
      if (push)
        wr_ptr <= bump(wr_ptr);
      if (pop)
        rd_ptr <= bump(rd_ptr);
      if (push && !pop)
        count <= count + 1'b1;
      else if (pop && !push)
        count <= count - 1'b1;
    end
  end
endmodule : byte_fifo
`default_nettype wire

// file: verilog/serial_flash_read_engine.sv
// Read-command engine of a serial NOR flash with register slave and prefetch buffer
`timescale 1ns/10ps
`default_nettype none
// What this block does
// - Single-line: address on rise, data on fall
// - Address advances per byte, wraps to zero
// - Fast read: eight dummy clocks before data
// - Reads ignored while write cycle busy
// - Dual-output: address on line 0, data two lines
// - Dual-I/O: address, dummy, data on two lines
// - Quad-output: serial address, data four lines
// - Quad-I/O: address, dummy, data four lines
// - Quad instruction eight serial or two quad clocks
// - Toggling indicator nibbles enter enhance mode
// - Dummy counts from configuration bits six, seven
// - DTR: nibble per edge, byte per clock
// - Any start address accepted, no alignment
module serial_flash_read_engine (
  input  wire logic        CLOCK,
  input  wire logic        RST_N,
  input  wire logic        CS_N,
  input  wire logic        SCLK,
  input  wire logic [3:0]  SIO_IN,
  output logic [3:0]       SIO_OUT,
  output logic [3:0]       SIO_OE,
  input  wire logic [3:0]  AVS_ADDRESS,
  input  wire logic        AVS_READ,
  input  wire logic        AVS_WRITE,
  input  wire logic [31:0] AVS_WRITEDATA,
  output logic [31:0]      AVS_READDATA,
  output logic             AVS_WAITREQUEST,
  output logic             MEM_REQ,
  output logic [23:0]      MEM_ADDR,
  input  wire logic        MEM_RVALID,
  input  wire logic [7:0]  MEM_RDATA
);
  flash_read_pkg::pins_t      pin_s1;      // Synchroniser first stage
  flash_read_pkg::pins_t      pin_s2;      // Synchroniser second stage
  logic                       sclk_d;      // Previous clock level
  logic                       rise;        // Serial clock rising
  logic                       fall;        // Serial clock falling
  flash_read_pkg::phase_t     phase;       // Frame phase
  flash_read_pkg::read_mode_t cur;         // Active read variant
  flash_read_pkg::read_mode_t dec;         // Decode of finished opcode
  logic [4:0]                 cnt;         // Edge counter within phase
  logic [7:0]                 cmd_shift;   // Instruction shifter
  logic [23:0]                addr_shift;  // Address shifter
  logic [7:0]                 mode_shift;  // Enhance indicator shifter
  logic                       enhance;     // Enhance mode active
  logic [7:0]                 next_cmd;
  logic [23:0]                next_addr;
  logic [7:0]                 next_mode;
  logic                       cmd_done;
  logic                       addr_edge;
  logic                       addr_done;
  logic                       mode_edge;
  logic                       dummy_done;
  logic                       out_edge;
  logic                       load;
  logic [7:0]                 out_shift;   // Byte being shifted out
  logic [7:0]                 out_byte;    // Fresh byte or remainder for the lines
  logic [3:0]                 bits_left;   // Bits still to send
  logic [23:0]                rd_addr;     // Address of next byte out
  logic [2:0]                 ctrl;        // Control register
  logic [7:0]                 cfg;         // Configuration register
  logic                       underrun;    // Sticky buffer-dry flag
  logic                       fetch_en;    // Prefetch allowed
  logic [23:0]                fetch_addr;  // Next byte to fetch
  logic                       pending;     // Fetch outstanding
  logic                       discard;     // Drop stale answer
  logic                       fifo_in_ready;
  logic                       fifo_out_valid;
  logic [7:0]                 fifo_out_data;
  logic                       reg_write;
  logic [1:0]                 dc_sel;

  // Shift new lines into the low end of a word
  function automatic logic [23:0] shift_in(input logic [23:0] r, input logic [3:0] s,
                                           input logic [2:0] lanes);
    unique case (lanes)
      flash_read_pkg::LANES_1: shift_in = {r[22:0], s[0]};
      flash_read_pkg::LANES_2: shift_in = {r[21:0], s[1:0]};
      default:                 shift_in = {r[19:0], s};
    endcase
  endfunction : shift_in

  // Last address edge index for a lane count
  function automatic logic [4:0] addr_last(input logic [2:0] lanes);
    unique case (lanes)
      flash_read_pkg::LANES_1: addr_last = 5'h17;
      flash_read_pkg::LANES_2: addr_last = 5'h0b;
      default:                 addr_last = 5'h05;
    endcase
  endfunction : addr_last

  // Instruction decode
  function automatic flash_read_pkg::read_mode_t decode_read(input logic [7:0] op,
      input logic [1:0] dc, input logic qe, input logic four_wire);
    flash_read_pkg::read_mode_t m;
    m = '0;
    m.addr_lanes = flash_read_pkg::LANES_1;
    m.data_lanes = flash_read_pkg::LANES_1;
    unique case (op)
      flash_read_pkg::OP_READ:
      begin
        m.valid = !four_wire;
        m.dummy = flash_read_pkg::DUMMY_NONE;
      end
      flash_read_pkg::OP_FAST_READ:
      begin
        m.valid = !four_wire;
        m.dummy = flash_read_pkg::DUMMY_SDR;
      end
      flash_read_pkg::OP_DUAL_OUT_READ:
      begin
        m.valid      = !four_wire;
        m.data_lanes = flash_read_pkg::LANES_2;
        m.dummy      = flash_read_pkg::DUMMY_SDR;
      end
      flash_read_pkg::OP_DUAL_IO_READ:
      begin
        m.valid      = !four_wire;
        m.addr_lanes = flash_read_pkg::LANES_2;
        m.data_lanes = flash_read_pkg::LANES_2;
        m.dummy      = dc[0] ? flash_read_pkg::DUMMY_DIO_1 : flash_read_pkg::DUMMY_DIO_0;
      end
      flash_read_pkg::OP_QUAD_OUT_READ:
      begin
        m.valid      = qe && !four_wire;
        m.data_lanes = flash_read_pkg::LANES_4;
        m.dummy      = flash_read_pkg::DUMMY_SDR;
      end
      flash_read_pkg::OP_QUAD_IO_READ:
      begin
        m.valid      = qe;
        m.addr_lanes = flash_read_pkg::LANES_4;
        m.data_lanes = flash_read_pkg::LANES_4;
        m.mode_bits  = 1'b1;
        unique case (dc)
          2'h0:    m.dummy = flash_read_pkg::DUMMY_QIO_0;
          2'h1:    m.dummy = flash_read_pkg::DUMMY_QIO_1;
          2'h2:    m.dummy = flash_read_pkg::DUMMY_QIO_2;
          default: m.dummy = flash_read_pkg::DUMMY_QIO_3;
        endcase
      end
      flash_read_pkg::OP_QUAD_DTR_READ:
      begin
        m.valid      = qe;
        m.addr_lanes = flash_read_pkg::LANES_4;
        m.data_lanes = flash_read_pkg::LANES_4;
        m.dtr        = 1'b1;
        m.mode_bits  = 1'b1;
        unique case (dc)
          2'h2:    m.dummy = flash_read_pkg::DUMMY_DTR_2;
          2'h3:    m.dummy = flash_read_pkg::DUMMY_DTR_3;
          default: m.dummy = flash_read_pkg::DUMMY_DTR_0;
        endcase
      end
      default: m.valid = 1'b0;  // Unknown codes are ignored
    endcase
    decode_read = m;
  endfunction : decode_read

  // Pin synchroniser, two stages plus clock history
  always_ff @(posedge CLOCK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      pin_s1 <= flash_read_pkg::PINS_IDLE;
      pin_s2 <= flash_read_pkg::PINS_IDLE;
      sclk_d <= 1'b0;
    end
    else
    begin
      pin_s1 <= '{cs_n: CS_N, sclk: SCLK, sio: SIO_IN};
      pin_s2 <= pin_s1;
      sclk_d <= pin_s2.sclk;
    end
  end

  // Edge events and phase-step terms
  always_comb
  begin
    rise       = pin_s2.sclk && !sclk_d && !pin_s2.cs_n;
    fall       = !pin_s2.sclk && sclk_d && !pin_s2.cs_n;
    dc_sel     = {cfg[flash_read_pkg::CFG_DC_HI], cfg[flash_read_pkg::CFG_DC_LO]};
    // Lines 3..1 are not looked at in a serial instruction
    next_cmd   = ctrl[flash_read_pkg::CTRL_FOUR_WIRE] ? {cmd_shift[3:0], pin_s2.sio}
                                                      : {cmd_shift[6:0], pin_s2.sio[0]};
    cmd_done   = (phase == flash_read_pkg::PH_CMD) && rise &&
                 (cnt == (ctrl[flash_read_pkg::CTRL_FOUR_WIRE] ? 5'h01 : 5'h07));
    dec        = decode_read(next_cmd, dc_sel, ctrl[flash_read_pkg::CTRL_QUAD_ENABLE],
                             ctrl[flash_read_pkg::CTRL_FOUR_WIRE]);
    next_addr  = shift_in(addr_shift, pin_s2.sio, cur.addr_lanes);
    // Both-edge address takes the falling half after each rising half
    addr_edge  = (phase == flash_read_pkg::PH_ADDR) && (rise || (fall && cur.dtr && cnt[0]));
    addr_done  = addr_edge && (cnt == addr_last(cur.addr_lanes));
    next_mode  = {mode_shift[3:0], pin_s2.sio};
    // Indicator: two rises single-rate, one rise and fall double-rate
    mode_edge  = (phase == flash_read_pkg::PH_DUMMY) && cur.mode_bits &&
                 ((rise && (cnt < (cur.dtr ? 5'h01 : 5'h02))) ||
                  (fall && cur.dtr && (cnt == 5'h01)));
    dummy_done = (phase == flash_read_pkg::PH_DUMMY) && rise &&
                 (cnt == 5'(cur.dummy) - 5'h01);
    out_edge   = (phase == flash_read_pkg::PH_DATA) && (fall || (rise && cur.dtr));
    load       = out_edge && (bits_left == 4'h0);
    // A dry buffer at a byte start sends the fill byte
    out_byte   = load ? (fifo_out_valid ? fifo_out_data : flash_read_pkg::UNDERRUN_BYTE)
                      : out_shift;
  end

  // Frame sequencer
  always_ff @(posedge CLOCK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      phase      <= flash_read_pkg::PH_CMD;
      cur        <= '0;
      cnt        <= 5'h00;
      cmd_shift  <= 8'h00;
      addr_shift <= 24'h000000;
      mode_shift <= 8'h00;
      enhance    <= 1'b0;
    end
    else if (pin_s2.cs_n)
    begin
      // Deselect ends the frame; enhance mode skips the next instruction unless busy
      phase <= (enhance && !ctrl[flash_read_pkg::CTRL_BUSY]) ? flash_read_pkg::PH_ADDR
                                                              : flash_read_pkg::PH_CMD;
      cnt   <= 5'h00;
    end
    else
    begin
      unique case (phase)
        flash_read_pkg::PH_CMD:
        begin
          if (rise)
          begin
            cmd_shift <= next_cmd;
            cnt       <= cnt + 5'h01;
          end
          if (cmd_done)
          begin
            cnt <= 5'h00;
            cur <= dec;
            // Busy internal cycle: ignore the read, leave that cycle alone
            if (!dec.valid || ctrl[flash_read_pkg::CTRL_BUSY])
              phase <= flash_read_pkg::PH_IGNORE;
            else
              phase <= flash_read_pkg::PH_ADDR;
          end
        end
        flash_read_pkg::PH_ADDR:
        begin
          if (addr_edge)
          begin
            addr_shift <= next_addr;
            cnt        <= cnt + 5'h01;
          end
          if (addr_done)
          begin
            cnt   <= 5'h00;
            phase <= (cur.dummy == flash_read_pkg::DUMMY_NONE) ? flash_read_pkg::PH_DATA
                                                               : flash_read_pkg::PH_DUMMY;
          end
        end
        flash_read_pkg::PH_DUMMY:
        begin
          if (mode_edge)
            mode_shift <= next_mode;
          if (rise)
            cnt <= cnt + 5'h01;
          if (dummy_done)
          begin
            phase   <= flash_read_pkg::PH_DATA;
            // Every upper nibble bit must differ from its lower partner
            enhance <= cur.mode_bits && ((mode_shift[7:4] ^ mode_shift[3:0]) == 4'hf);
          end
        end
        flash_read_pkg::PH_DATA:   phase <= flash_read_pkg::PH_DATA;
        flash_read_pkg::PH_IGNORE: phase <= flash_read_pkg::PH_IGNORE;
        default:                   phase <= flash_read_pkg::PH_IGNORE;
      endcase
    end
  end

  // Data shifter and line drivers
  always_ff @(posedge CLOCK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      out_shift <= 8'h00;
      bits_left <= 4'h0;
      rd_addr   <= 24'h000000;
      SIO_OUT   <= 4'h0;
      SIO_OE    <= 4'h0;
    end
    else if (pin_s2.cs_n || phase != flash_read_pkg::PH_DATA)
    begin
      bits_left <= 4'h0;
      SIO_OE    <= 4'h0;
      if (addr_done)
        rd_addr <= next_addr;
    end
    else if (out_edge)
    begin
      unique case (cur.data_lanes)
        flash_read_pkg::LANES_1:
        begin
          SIO_OUT   <= {2'h0, out_byte[7], 1'b0};
          SIO_OE    <= 4'h2;
          out_shift <= {out_byte[6:0], 1'b0};
          bits_left <= load ? 4'h7 : bits_left - 4'h1;
        end
        flash_read_pkg::LANES_2:
        begin
          SIO_OUT   <= {2'h0, out_byte[7:6]};
          SIO_OE    <= 4'h3;
          out_shift <= {out_byte[5:0], 2'h0};
          bits_left <= load ? 4'h6 : bits_left - 4'h2;
        end
        default:
        begin
          SIO_OUT   <= out_byte[7:4];
          SIO_OE    <= 4'hf;
          out_shift <= {out_byte[3:0], 4'h0};
          bits_left <= load ? 4'h4 : bits_left - 4'h4;
        end
      endcase
      if (load)
        rd_addr <= rd_addr + 24'h000001;
    end
  end

  // Prefetch from the array into the buffer
  always_ff @(posedge CLOCK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      fetch_en   <= 1'b0;
      fetch_addr <= 24'h000000;
      pending    <= 1'b0;
      discard    <= 1'b0;
      MEM_REQ    <= 1'b0;
      MEM_ADDR   <= 24'h000000;
    end
    else
    begin
      MEM_REQ <= 1'b0;
      if (MEM_RVALID)
      begin
        pending <= 1'b0;
        discard <= 1'b0;
      end
      if (addr_done)
      begin
        // Restart at the new address; an answer still in flight is stale
        fetch_en   <= 1'b1;
        fetch_addr <= next_addr;
        discard    <= pending && !MEM_RVALID;
      end
      else if (pin_s2.cs_n)
        fetch_en <= 1'b0;
      else if (fetch_en && !pending && !discard && fifo_in_ready)
      begin
        MEM_REQ    <= 1'b1;
        MEM_ADDR   <= fetch_addr;
        fetch_addr <= fetch_addr + 24'h000001;
        pending    <= 1'b1;
      end
    end
  end

  // Prefetch buffer
  byte_fifo #(
    .WIDTH (flash_read_pkg::DATA_W),
    .DEPTH (flash_read_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clock     (CLOCK),
    .rst_n     (RST_N),
    .flush     (addr_done),
    .in_valid  (MEM_RVALID && !discard),
    .in_ready  (fifo_in_ready),
    .in_data   (MEM_RDATA),
    .out_valid (fifo_out_valid),
    .out_ready (load),
    .out_data  (fifo_out_data)
  );

  assign reg_write = AVS_WRITE && !AVS_WAITREQUEST;

  // Bus handshake: one wait cycle, then the access completes
  always_ff @(posedge CLOCK or negedge RST_N)
  begin
    if (!RST_N)
      AVS_WAITREQUEST <= 1'b1;
    else
      AVS_WAITREQUEST <= !((AVS_READ || AVS_WRITE) && AVS_WAITREQUEST);
  end

  // Control and configuration registers
  always_ff @(posedge CLOCK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      ctrl <= flash_read_pkg::CTRL_RESET;
      cfg  <= flash_read_pkg::CONFIG_RESET;
    end
    else if (reg_write && AVS_ADDRESS == flash_read_pkg::REG_CTRL)
      ctrl <= AVS_WRITEDATA[2:0];
    else if (reg_write && AVS_ADDRESS == flash_read_pkg::REG_CONFIG)
      cfg <= AVS_WRITEDATA[7:0];
  end

  // Sticky underrun; a new event beats a clear
  always_ff @(posedge CLOCK or negedge RST_N)
  begin
    if (!RST_N)
      underrun <= 1'b0;
    else if (load && !fifo_out_valid)
      underrun <= 1'b1;
    else if (reg_write && AVS_ADDRESS == flash_read_pkg::REG_STATUS &&
             AVS_WRITEDATA[flash_read_pkg::STAT_UNDERRUN])
      underrun <= 1'b0;
  end

  // Read data, captured as the wait cycle ends
  always_ff @(posedge CLOCK or negedge RST_N)
  begin
    if (!RST_N)
      AVS_READDATA <= 32'h00000000;
    else if (AVS_READ && AVS_WAITREQUEST)
    begin
      unique case (AVS_ADDRESS)
        flash_read_pkg::REG_CTRL:   AVS_READDATA <= {29'h0, ctrl};
        flash_read_pkg::REG_CONFIG: AVS_READDATA <= {24'h0, cfg};
        flash_read_pkg::REG_STATUS: AVS_READDATA <= {25'h0, phase, 1'b0, pending, underrun,
                                                     enhance};
        flash_read_pkg::REG_ADDR:   AVS_READDATA <= {8'h00, rd_addr};
        default:                    AVS_READDATA <= 32'h00000000;  // Unmapped reads zero
      endcase
    end
  end
endmodule : serial_flash_read_engine
`default_nettype wire

// file: sim/flash_read_monitor.sv
// Bus and pin timing checks for the flash read engine
`timescale 1ns/10ps
`default_nettype none
module flash_read_monitor (
  input wire logic        CLOCK,
  input wire logic        RST_N,
  input wire logic        CS_N,
  input wire logic        AVS_READ,
  input wire logic        AVS_WRITE,
  input wire logic        AVS_WAITREQUEST,
  input wire logic [31:0] AVS_READDATA,
  input wire logic [3:0]  SIO_OE,
  input wire logic        MEM_REQ,
  input wire logic [23:0] MEM_ADDR
);
  default clocking @(posedge CLOCK); endclocking
  default disable iff (!RST_N);
  property p_ans;
    (AVS_READ || AVS_WRITE) && AVS_WAITREQUEST |-> ##[1:2] !AVS_WAITREQUEST;
  endproperty
  a_ans: assert property (p_ans) else $error("bus answer late");
  property p_one; !AVS_WAITREQUEST |=> AVS_WAITREQUEST; endproperty
  a_one: assert property (p_one) else $error("wait low too long");
  property p_idle; !AVS_READ && !AVS_WRITE |=> AVS_WAITREQUEST; endproperty
  a_idle: assert property (p_idle) else $error("answer without request");
  property p_hold; AVS_WAITREQUEST && $past(AVS_WAITREQUEST) |-> $stable(AVS_READDATA); endproperty
  a_hold: assert property (p_hold) else $error("read data moved");
  property p_off; CS_N [*5] |-> SIO_OE == 4'h0; endproperty
  a_off: assert property (p_off) else $error("drive while deselected");
  property p_lanes; SIO_OE inside {4'h0, 4'h2, 4'h3, 4'hf}; endproperty
  a_lanes: assert property (p_lanes) else $error("bad lane enable");
  property p_req; MEM_REQ |=> !MEM_REQ; endproperty
  a_req: assert property (p_req) else $error("fetch not a pulse");
  property p_addr; !MEM_REQ |-> $stable(MEM_ADDR); endproperty
  a_addr: assert property (p_addr) else $error("fetch address moved");
endmodule : flash_read_monitor
bind serial_flash_read_engine flash_read_monitor u_mon (.*);
`default_nettype wire

// file: sim/flash_array_model.sv
// Memory array stand-in answering each fetch on the next edge
`timescale 1ns/10ps
`default_nettype none
module flash_array_model (
  input wire logic        clock,
  input wire logic        rst_n,
  input wire logic        mem_req,
  input wire logic [23:0] mem_addr,
  output logic            mem_rvalid,
  output logic [7:0]      mem_rdata
);
  // Byte derived from address; data toggles when not valid
  always_ff @(posedge clock or negedge rst_n)
    if (!rst_n)
    begin
      mem_rvalid <= 1'b0;
      mem_rdata  <= 8'h00;
    end
    else
    begin
      mem_rvalid <= mem_req;
      mem_rdata  <= mem_req ? mem_addr[7:0] ^ mem_addr[23:16] ^ 8'h5a : ~mem_rdata;
    end
endmodule : flash_array_model
`default_nettype wire

// file: sim/test_serial_flash_read_engine.sv
// Self-checking bench for the flash read engine
`timescale 1ns/10ps
`default_nettype none
module test_serial_flash_read_engine;
  logic        CLOCK = 0, RST_N = 0, CS_N = 1, SCLK = 0, AVS_READ = 0, AVS_WRITE = 0, four_wire_command_mode = 0;
  logic [3:0]  SIO_IN = 0, AVS_ADDRESS = 0, SIO_OUT, SIO_OE, pins, oe;
  logic [31:0] AVS_WRITEDATA = 0, AVS_READDATA, rd;
  logic        AVS_WAITREQUEST, MEM_REQ, MEM_RVALID;
  logic [23:0] MEM_ADDR, ra;
  logic [7:0]  MEM_RDATA, ind = 0;
  int          n_fail = 0, total_checks = 0;
  logic [7:0]  ops [6] = '{8'h03, 8'h0b, 8'h3b, 8'hbb, 8'h6b, 8'heb};
  int          al [6] = '{1, 1, 1, 2, 1, 4};
  int          dl [6] = '{1, 1, 2, 2, 4, 4};
  int          nd [6] = '{0, 8, 8, 4, 8, 6};
  always #5 CLOCK = ~CLOCK;
  serial_flash_read_engine u_dut (.*);
  flash_array_model u_mem (.clock(CLOCK), .rst_n(RST_N), .mem_req(MEM_REQ),
    .mem_addr(MEM_ADDR), .mem_rvalid(MEM_RVALID), .mem_rdata(MEM_RDATA));
  task check(input logic [31:0] seen, exp, input string what);
    total_checks++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  // Byte the array stand-in holds at an address
  function automatic logic [7:0] exp_byte(input logic [23:0] a);
    return a[7:0] ^ a[23:16] ^ 8'h5a;
  endfunction : exp_byte
  task results;
    $display("checks %0d errors %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : results
  // One bus access held until waitrequest is seen low
  task bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    AVS_ADDRESS <= a;
    AVS_WRITEDATA <= d;
    AVS_READ <= !wr;
    AVS_WRITE <= wr;
    @(posedge CLOCK);
    while (AVS_WAITREQUEST) @(posedge CLOCK);
    rd = AVS_READDATA;
    AVS_READ <= 1'b0;
    AVS_WRITE <= 1'b0;
    @(posedge CLOCK);
  endtask : bus
  // One serial clock: drive, sample before rise, rise, fall
  task sclk_cycle(input logic [3:0] v);
    SIO_IN <= v;
    repeat (8) @(posedge CLOCK);
    pins = SIO_OUT;
    oe = SIO_OE;
    SCLK <= 1'b1;
    repeat (8) @(posedge CLOCK);
    SCLK <= 1'b0;
  endtask : sclk_cycle
  // Whole read frame; ok low means the read must be refused
  task frame(input logic [7:0] op, input int w, n, d, input logic [23:0] a, input logic ok);
    logic [7:0] b;
    CS_N <= 1'b0;
    for (int i = four_wire_command_mode ? 4 : 7; i >= 0; i -= four_wire_command_mode ? 4 : 1)
      sclk_cycle(four_wire_command_mode ? 4'(op >> i) : {3'h0, op[i]});
    for (int i = 24 - w; i >= 0; i -= w) sclk_cycle(4'((a >> i) & ((1 << w) - 1)));
    for (int i = 0; i < d; i++) sclk_cycle(i < 2 ? 4'(ind >> (i ? 0 : 4)) : 4'h0);
    for (int k = 0; k < 2; k++)
    begin
      for (int j = 0; j < 8 / n; j++)
      begin
        sclk_cycle(4'h0);
        b = 8'((b << n) | (n == 1 ? pins[1] : pins & ((1 << n) - 1)));
        check(32'(oe), ok ? (n == 1 ? 2 : (1 << n) - 1) : 0, "lane enable");
      end
      if (ok)
        check(32'(b), 32'(exp_byte(a + 24'(k))), "data byte");
    end
    CS_N <= 1'b1;
    repeat (8) @(posedge CLOCK);
  endtask : frame
  initial
  begin
    void'($urandom(36370));
    repeat (6) @(posedge CLOCK);
    RST_N <= 1'b1;
    repeat (4) @(posedge CLOCK);
    bus(0, 4'h4, 0);
    check(rd, 0, "config reset");
    bus(0, 4'h2, 0);
    check(rd, 0, "unmapped read");
    bus(1, 4'h0, 32'h1);
    foreach (ops[i]) frame(ops[i], al[i], dl[i], nd[i], i ? 24'($urandom) : 24'hffffff, 1);
    bus(1, 4'h4, 32'hc0);
    frame(8'heb, 4, 4, 10, 24'($urandom), 1);
    bus(1, 4'h0, 32'h3);
    four_wire_command_mode = 1;
    ind = 8'h5a;
    ra = 24'($urandom);
    frame(8'heb, 4, 4, 10, ra, 1);
    bus(0, 4'hc, 0);
    check(rd, 32'(ra + 24'h2), "next address");
    bus(0, 4'h8, 0);
    check(rd, 32'h11, "status");
    four_wire_command_mode = 0;
    bus(1, 4'h0, 32'h5);
    frame(8'h03, 1, 1, 0, 24'($urandom), 0);
    results();
  end
  initial
  begin
    #500000;
    n_fail++;
    results();
  end
endmodule : test_serial_flash_read_engine
`default_nettype wire
